// ===== aux_map_pkg.sv
// shared constants, types and code decoding for the auxiliary input mapper
`default_nettype none
package aux_map_pkg;

  localparam int NUM_INPUTS    = 4;
  localparam int CODE_W        = 4;
  localparam int PRESS_W       = 16;
  localparam int SEC_W         = 5;

  // one-second tick, derived from the clock period
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_TIME_NS  = 1_000_000_000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  // qualification times in whole seconds
  localparam logic [SEC_W-1:0] ON_SECS            = 5'h01;
  localparam logic [SEC_W-1:0] STD_OFF_SECS       = 5'h01;
  localparam logic [SEC_W-1:0] FLOAT_OFF_SECS     = 5'h1E;
  localparam logic [SEC_W-1:0] LOWP_AUTO_OFF_SECS = 5'h02;

  // input function codes
  localparam logic [CODE_W-1:0] CODE_DISABLED     = 4'h0;
  localparam logic [CODE_W-1:0] CODE_FLOAT_NO     = 4'h1;
  localparam logic [CODE_W-1:0] CODE_FLOAT_NC     = 4'h2;
  localparam logic [CODE_W-1:0] CODE_AUX_NO       = 4'h3;
  localparam logic [CODE_W-1:0] CODE_AUX_NC       = 4'h4;
  localparam logic [CODE_W-1:0] CODE_DIS_NO       = 4'h5;
  localparam logic [CODE_W-1:0] CODE_DIS_NC       = 4'h6;
  localparam logic [CODE_W-1:0] CODE_DIS_RST_NO   = 4'h7;
  localparam logic [CODE_W-1:0] CODE_DIS_RST_NC   = 4'h8;
  localparam logic [CODE_W-1:0] CODE_RST_NO       = 4'h9;
  localparam logic [CODE_W-1:0] CODE_LOWP_AUTO_NO = 4'hA;
  localparam logic [CODE_W-1:0] CODE_LOWP_AUTO_NC = 4'hB;
  localparam logic [CODE_W-1:0] CODE_LOWP_MAN_NO  = 4'hC;
  localparam logic [CODE_W-1:0] CODE_LOWP_MAN_NC  = 4'hD;

  typedef struct packed {
    logic active_high;
    logic float_f;
    logic aux_f;
    logic disable_f;
    logic reset_f;
    logic lowp_f;
    logic lowp_manual;
  } func_decode_t;

  typedef struct packed {
    logic water_lack;
    logic motor_disabled;
    logic low_intake;
    logic aux_setpoint;
    logic fault_reset;
    logic system_block;
  } status_t;

  typedef enum logic {
    Q_OFF = 1'b0,
    Q_ON  = 1'b1
  } qual_state_t;

  function automatic func_decode_t decode_code(
      input logic [CODE_W-1:0] code);
    func_decode_t d;
    d = '0;
    case (code)
      CODE_FLOAT_NO: begin
        d.active_high = 1'h1;
        d.float_f     = 1'h1;
      end
      CODE_FLOAT_NC: d.float_f = 1'h1;
      CODE_AUX_NO: begin
        d.active_high = 1'h1;
        d.aux_f       = 1'h1;
      end
      CODE_AUX_NC: d.aux_f = 1'h1;
      CODE_DIS_NO: begin
        d.active_high = 1'h1;
        d.disable_f   = 1'h1;
      end
      CODE_DIS_NC: d.disable_f = 1'h1;
      CODE_DIS_RST_NO: begin
        d.active_high = 1'h1;
        d.disable_f   = 1'h1;
        d.reset_f     = 1'h1;
      end
      CODE_DIS_RST_NC: begin
        d.disable_f   = 1'h1;
        d.reset_f     = 1'h1;
      end
      CODE_RST_NO: begin
        d.active_high = 1'h1;
        d.reset_f     = 1'h1;
      end
      CODE_LOWP_AUTO_NO: begin
        d.active_high = 1'h1;
        d.lowp_f      = 1'h1;
      end
      CODE_LOWP_AUTO_NC: d.lowp_f = 1'h1;
      CODE_LOWP_MAN_NO: begin
        d.active_high = 1'h1;
        d.lowp_f      = 1'h1;
        d.lowp_manual = 1'h1;
      end
      CODE_LOWP_MAN_NC: begin
        d.lowp_f      = 1'h1;
        d.lowp_manual = 1'h1;
      end
      default: d = '0;
    endcase
    return d;
  endfunction : decode_code

endpackage : aux_map_pkg
`default_nettype wire

// ===== sec_tick_gen.sv
// one-second enable pulse divided down from the reference clock
`default_nettype none
module sec_tick_gen #(
  parameter int TICK_CYCLES = 50_000_000
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  output logic      tick_out
);

  localparam int CW = $clog2(TICK_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          tick_reg;
  logic          tick_next;

  always_comb begin
    cnt_next  = cnt_reg + 1'b1;
    tick_next = 1'b0;
    if (cnt_reg == LAST) begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_out = tick_reg;

  tick_single_a: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    tick_reg |=> !tick_reg)
    else $error("second tick lasted more than one cycle");

endmodule : sec_tick_gen
`default_nettype wire

// ===== sec_qualifier.sv
// holds a level until it has stood opposite for whole seconds
`default_nettype none
module sec_qualifier
  import aux_map_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             tick_in,
  input  wire logic             clear_in,
  input  wire logic             level_in,
  input  wire logic [SEC_W-1:0] on_secs_in,
  input  wire logic [SEC_W-1:0] off_secs_in,
  output logic                  state_out
);

  qual_state_t      state_reg;
  qual_state_t      state_next;
  logic [SEC_W-1:0] cnt_reg;
  logic [SEC_W-1:0] cnt_next;
  logic [SEC_W-1:0] limit;

  // the first tick seen may come early, so one extra tick is needed
  // to be sure that the full time has passed
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    limit      = (state_reg == Q_ON) ? off_secs_in : on_secs_in;
    case (state_reg)
      Q_OFF, Q_ON: begin
        if (clear_in) begin
          state_next = Q_OFF;
          cnt_next   = '0;
        end else if (level_in == (state_reg == Q_ON)) begin
          cnt_next = '0;
        end else if (tick_in) begin
          if (cnt_reg >= limit) begin
            state_next = (state_reg == Q_ON) ? Q_OFF : Q_ON;
            cnt_next   = '0;
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
      end
      default: begin
        state_next = Q_OFF;
        cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_reg <= Q_OFF;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign state_out = (state_reg == Q_ON);

  qual_rise_a: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    $rose(state_reg == Q_ON) |->
      $past(tick_in && level_in && !clear_in && cnt_reg >= on_secs_in))
    else $error("qualified on before the hold time");

  qual_fall_a: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    $fell(state_reg == Q_ON) && !$past(clear_in) |->
      $past(tick_in && !level_in && cnt_reg >= off_secs_in))
    else $error("qualified off before the release time");

  qual_restart_a: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (level_in == (state_reg == Q_ON)) |=> cnt_reg == '0)
    else $error("hold count not restarted by a level change");

endmodule : sec_qualifier
`default_nettype wire

// ===== aux_input_function_mapper.sv
// maps four auxiliary inputs to their configured pump functions
`default_nettype none
module aux_input_function_mapper
  import aux_map_pkg::*;
#(
  parameter int ONE_SEC_CYCLES = TICK_CYCLES
) (
  input  wire logic                              REF_CLK_IN,
  input  wire logic                              RST_B_IN,
  input  wire logic [NUM_INPUTS-1:0]             AUX_INPUT_N_IN,
  input  wire logic [NUM_INPUTS-1:0][CODE_W-1:0] INPUT_FUNCTION_CODE_IN,
  input  wire logic [NUM_INPUTS-1:0][PRESS_W-1:0] AUX_SETPOINT_PRESSURE_IN,
  input  wire logic [PRESS_W-1:0]                MAIN_SETPOINT_PRESSURE_IN,
  input  wire logic                              MANUAL_RESET_IN,
  output logic      [PRESS_W-1:0]                ACTIVE_SETPOINT_OUT,
  output logic      [NUM_INPUTS-1:0]             AUX_SETPOINT_SEL_OUT,
  output logic                                   AUX_SETPOINT_INDICATOR_OUT,
  output logic                                   WATER_LACK_INDICATOR_OUT,
  output logic                                   MOTOR_DISABLED_INDICATOR_OUT,
  output logic                               LOW_INTAKE_PRESSURE_INDICATOR_OUT,
  output logic                                   FAULT_RESET_OUT,
  output logic                                   SYSTEM_BLOCK_OUT
);

  // a long float release keeps a splashing float from cycling the pumps
  function automatic logic [SEC_W-1:0] off_secs_for(input func_decode_t d);
    if (d.float_f) begin
      return FLOAT_OFF_SECS;
    end
    if (d.lowp_f && !d.lowp_manual) begin
      return LOWP_AUTO_OFF_SECS;
    end
    return STD_OFF_SECS;
  endfunction : off_secs_for

  logic                          tick;
  func_decode_t                  dec     [NUM_INPUTS];
  logic [SEC_W-1:0]              off_s   [NUM_INPUTS];
  logic [NUM_INPUTS-1:0]         level;
  logic [NUM_INPUTS-1:0]         clear;
  logic [NUM_INPUTS-1:0]         q_on;
  logic [NUM_INPUTS-1:0]         float_m;
  logic [NUM_INPUTS-1:0]         aux_m;
  logic [NUM_INPUTS-1:0]         dis_m;
  logic [NUM_INPUTS-1:0]         rst_m;
  logic [NUM_INPUTS-1:0]         lowp_m;
  logic [NUM_INPUTS-1:0]         manual_m;

  logic [NUM_INPUTS-1:0][CODE_W-1:0] code_reg;
  logic [NUM_INPUTS-1:0][CODE_W-1:0] code_next;
  logic [NUM_INPUTS-1:0]         qprev_reg;
  logic [NUM_INPUTS-1:0]         qprev_next;
  logic [NUM_INPUTS-1:0]         lowp_reg;
  logic [NUM_INPUTS-1:0]         lowp_next;
  logic [PRESS_W-1:0]            setpoint_reg;
  logic [PRESS_W-1:0]            setpoint_next;
  logic [NUM_INPUTS-1:0]         sel_reg;
  logic [NUM_INPUTS-1:0]         sel_next;
  status_t                       status_reg;
  status_t                       status_next;
  logic                          fault_reset;
  logic                          found;

  sec_tick_gen #(
    .TICK_CYCLES (ONE_SEC_CYCLES)
  ) u_tick (
    .clk_in   (REF_CLK_IN),
    .rst_b_in (RST_B_IN),
    .tick_out (tick)
  );

  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_in
    assign dec[i]      = decode_code(INPUT_FUNCTION_CODE_IN[i]);
    assign off_s[i]    = off_secs_for(dec[i]);
    assign float_m[i]  = dec[i].float_f;
    assign aux_m[i]    = dec[i].aux_f;
    assign dis_m[i]    = dec[i].disable_f;
    assign rst_m[i]    = dec[i].reset_f;
    assign lowp_m[i]   = dec[i].lowp_f;
    assign manual_m[i] = dec[i].lowp_manual;
    // closed-contact codes see an absent signal as the asserted state
    assign level[i] = (dec[i].active_high ? AUX_INPUT_N_IN[i]
                                          : ~AUX_INPUT_N_IN[i]) &
                      (INPUT_FUNCTION_CODE_IN[i] != CODE_DISABLED);
    // a new code starts from a clean state so no stale function lingers
    assign clear[i] = (INPUT_FUNCTION_CODE_IN[i] != code_reg[i]) ||
                      (INPUT_FUNCTION_CODE_IN[i] == CODE_DISABLED);

    sec_qualifier u_qual (
      .clk_in      (REF_CLK_IN),
      .rst_b_in    (RST_B_IN),
      .tick_in     (tick),
      .clear_in    (clear[i]),
      .level_in    (level[i]),
      .on_secs_in  (ON_SECS),
      .off_secs_in (off_s[i]),
      .state_out   (q_on[i])
    );

    input_off_a: assert property (
      @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      INPUT_FUNCTION_CODE_IN[i] == CODE_DISABLED &&
        $past(INPUT_FUNCTION_CODE_IN[i]) == CODE_DISABLED |->
        !q_on[i] && !lowp_reg[i])
      else $error("disabled input still acting");

    aux_lowest_a: assert property (
      @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (aux_m[i] && q_on[i]) |=>
        ACTIVE_SETPOINT_OUT <= $past(AUX_SETPOINT_PRESSURE_IN[i]))
      else $error("setpoint above an active auxiliary pressure");

    lowp_manual_hold_a: assert property (
      @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      lowp_reg[i] && manual_m[i] && !clear[i] &&
        !(fault_reset && !level[i]) |=> lowp_reg[i])
      else $error("manual low pressure block cleared without reset");

    lowp_entry_a: assert property (
      @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      $rose(lowp_reg[i]) |-> $past(lowp_m[i] && q_on[i] && !qprev_reg[i]))
      else $error("low pressure block set without a qualified edge");

    lowp_auto_clear_a: assert property (
      @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      lowp_reg[i] && lowp_m[i] && !manual_m[i] && !q_on[i] |=> !lowp_reg[i])
      else $error("automatic low pressure block not cleared");

    float_code_a: assert property (
      @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      float_m[i] && q_on[i] |=> WATER_LACK_INDICATOR_OUT)
      else $error("qualified float input without water lack");

    motor_code_a: assert property (
      @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      dis_m[i] && q_on[i] |=>
        MOTOR_DISABLED_INDICATOR_OUT && SYSTEM_BLOCK_OUT)
      else $error("qualified disable input without motor stop");

    float_release_a: assert property (
      @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      float_m[i] |-> off_s[i] == FLOAT_OFF_SECS)
      else $error("float input not given the long release time");

    lowp_release_a: assert property (
      @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      lowp_m[i] && !manual_m[i] |-> off_s[i] == LOWP_AUTO_OFF_SECS)
      else $error("automatic low pressure release time wrong");

    aux_release_a: assert property (
      @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      aux_m[i] |-> off_s[i] == STD_OFF_SECS)
      else $error("auxiliary setpoint release time wrong");

    code_off_a: assert property (
      @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      INPUT_FUNCTION_CODE_IN[i] == CODE_DISABLED |=> !q_on[i])
      else $error("disabled input left its filter on");
  end

  // a fault reset is the qualified leading edge of a reset input, or the manual reset input
  assign fault_reset = |(q_on & ~qprev_reg & rst_m) | MANUAL_RESET_IN;

  always_comb begin
    code_next   = INPUT_FUNCTION_CODE_IN;
    qprev_next  = q_on;
    lowp_next   = lowp_reg;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      // set wins over any clear arriving in the same cycle
      if (lowp_m[i] && q_on[i] && !qprev_reg[i]) begin
        lowp_next[i] = 1'b1;
      end else if (!lowp_m[i] || clear[i]) begin
        lowp_next[i] = 1'b0;
      end else if (!manual_m[i] && !q_on[i]) begin
        lowp_next[i] = 1'b0;
      end else if (fault_reset && !level[i]) begin
        lowp_next[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_B_IN) begin
      code_reg  <= '0;
      qprev_reg <= '0;
      lowp_reg  <= '0;
    end else begin
      code_reg  <= code_next;
      qprev_reg <= qprev_next;
      lowp_reg  <= lowp_next;
    end
  end

  always_comb begin
    setpoint_next = MAIN_SETPOINT_PRESSURE_IN;
    sel_next      = '0;
    found         = 1'b0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (aux_m[i] && q_on[i] &&
          (!found || AUX_SETPOINT_PRESSURE_IN[i] < setpoint_next)) begin
        setpoint_next = AUX_SETPOINT_PRESSURE_IN[i];
        sel_next      = '0;
        sel_next[i]   = 1'b1;
        found         = 1'b1;
      end
    end
    status_next                = '0;
    status_next.aux_setpoint   = found;
    status_next.water_lack     = |(q_on & float_m);
    status_next.motor_disabled = |(q_on & dis_m);
    status_next.low_intake     = |lowp_reg;
    status_next.fault_reset    = fault_reset;
    // any of these stops the whole pumping system
    status_next.system_block   = status_next.water_lack |
                                 status_next.motor_disabled |
                                 status_next.low_intake;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_B_IN) begin
      setpoint_reg <= '0;
      sel_reg      <= '0;
      status_reg   <= '0;
    end else begin
      setpoint_reg <= setpoint_next;
      sel_reg      <= sel_next;
      status_reg   <= status_next;
    end
  end

  assign ACTIVE_SETPOINT_OUT               = setpoint_reg;
  assign AUX_SETPOINT_SEL_OUT              = sel_reg;
  assign AUX_SETPOINT_INDICATOR_OUT        = status_reg.aux_setpoint;
  assign WATER_LACK_INDICATOR_OUT          = status_reg.water_lack;
  assign MOTOR_DISABLED_INDICATOR_OUT      = status_reg.motor_disabled;
  assign LOW_INTAKE_PRESSURE_INDICATOR_OUT = status_reg.low_intake;
  assign FAULT_RESET_OUT                   = status_reg.fault_reset;
  assign SYSTEM_BLOCK_OUT                  = status_reg.system_block;

  water_or_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    ##1 WATER_LACK_INDICATOR_OUT == $past(|(q_on & float_m)))
    else $error("water lack indicator not the OR of float inputs");

  float_blocks_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    WATER_LACK_INDICATOR_OUT |-> SYSTEM_BLOCK_OUT)
    else $error("water lack without system block");

  main_setpoint_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    !(|(q_on & aux_m)) |=>
      ACTIVE_SETPOINT_OUT == $past(MAIN_SETPOINT_PRESSURE_IN) &&
      !AUX_SETPOINT_INDICATOR_OUT)
    else $error("main setpoint not used with no auxiliary active");

  aux_indicator_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    |(q_on & aux_m) |=>
      AUX_SETPOINT_INDICATOR_OUT && $onehot(AUX_SETPOINT_SEL_OUT))
    else $error("auxiliary setpoint shown without indicator");

  motor_off_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    ##1 MOTOR_DISABLED_INDICATOR_OUT == $past(|(q_on & dis_m)))
    else $error("motor disabled indicator wrong");

  reset_pulse_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    |(q_on & ~qprev_reg & rst_m) |=> FAULT_RESET_OUT)
    else $error("fault reset pulse missing");

  lowp_or_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    ##1 LOW_INTAKE_PRESSURE_INDICATOR_OUT == $past(|lowp_reg))
    else $error("low intake indicator not the OR of blocks");

  block_or_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    SYSTEM_BLOCK_OUT == (WATER_LACK_INDICATOR_OUT ||
      MOTOR_DISABLED_INDICATOR_OUT || LOW_INTAKE_PRESSURE_INDICATOR_OUT))
    else $error("system block not the OR of blocking indicators");

  fault_source_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    FAULT_RESET_OUT |-> $past(fault_reset))
    else $error("fault reset pulse without a source");

endmodule : aux_input_function_mapper
`default_nettype wire

// ===== aux_contact_bank.sv
// contact bank model: float, pressure switches and external contacts
`default_nettype none
module aux_contact_bank
  import aux_map_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic [NUM_INPUTS-1:0] closed_in,
  input  wire logic                  bounce_in,
  output logic      [NUM_INPUTS-1:0] pins_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [NUM_INPUTS-1:0] last;
  logic [NUM_INPUTS-1:0] moving;
  int                    chatter;

  initial begin
    pins_out = '0;
    last = '0;
    moving = '0;
    chatter = 0;
  end

  // real contacts chatter a few cycles before they settle, so the
  // filter sees a restart rather than a clean edge
  always @(negedge clk_in) begin
    if (closed_in != last && bounce_in) begin
      chatter = 3;
      moving = closed_in ^ last;
    end
    last = closed_in;
    if (chatter > 0) begin
      pins_out <= pins_out ^ moving;
      chatter--;
    end else begin
      pins_out <= closed_in;
    end
  end
endmodule : aux_contact_bank
`default_nettype wire

// ===== test_aux_input_function_mapper.sv
// self-checking bench for the auxiliary input function mapper
`default_nettype none
module test_aux_input_function_mapper
  import aux_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [CODE_W-1:0] code;
    logic              pin;
    logic [4:0]        exp;
  } row_t;

  // exp: water, motor, low intake, aux indicator, fault reset pulse
  row_t rows [23] = '{
    '{4'h0, 1'b1, 5'h00}, '{4'h0, 1'b0, 5'h00}, '{4'h1, 1'b1, 5'h10},
    '{4'h1, 1'b0, 5'h00}, '{4'h2, 1'b0, 5'h10}, '{4'h2, 1'b1, 5'h00},
    '{4'h3, 1'b1, 5'h02}, '{4'h4, 1'b0, 5'h02}, '{4'h4, 1'b1, 5'h00},
    '{4'h5, 1'b1, 5'h08}, '{4'h6, 1'b0, 5'h08}, '{4'h6, 1'b1, 5'h00},
    '{4'h7, 1'b1, 5'h09}, '{4'h8, 1'b0, 5'h09}, '{4'h9, 1'b1, 5'h01},
    '{4'h9, 1'b0, 5'h00}, '{4'hA, 1'b1, 5'h04}, '{4'hB, 1'b0, 5'h04},
    '{4'hC, 1'b1, 5'h04}, '{4'hD, 1'b0, 5'h04}, '{4'hD, 1'b1, 5'h00},
    '{4'hE, 1'b1, 5'h00}, '{4'hF, 1'b0, 5'h00}};

  logic                                clk;
  logic                                rst_b;
  logic                                bounce;
  logic                                man_rst;
  logic [NUM_INPUTS-1:0]               cmd;
  logic [NUM_INPUTS-1:0]               pins;
  logic [NUM_INPUTS-1:0][CODE_W-1:0]   codes;
  logic [NUM_INPUTS-1:0][PRESS_W-1:0]  aux_p;
  logic [PRESS_W-1:0]                  main_p;
  logic [PRESS_W-1:0]                  sp;
  logic [PRESS_W-1:0]                  exp_sp;
  logic [NUM_INPUTS-1:0]               sel;
  logic                                aux_ind;
  logic                                water;
  logic                                motor;
  logic                                lowp;
  logic                                fault;
  logic                                block;
  int                                  bad_count;
  int                                  samples_checked;
  int                                  fr_count;
  int                                  n;
  int                                  k;

  aux_contact_bank bank (
    .clk_in    (clk),
    .closed_in (cmd),
    .bounce_in (bounce),
    .pins_out  (pins)
  );

  aux_input_function_mapper #(.ONE_SEC_CYCLES(8)) dut (
    .REF_CLK_IN                        (clk),
    .RST_B_IN                          (rst_b),
    .AUX_INPUT_N_IN                    (pins),
    .INPUT_FUNCTION_CODE_IN            (codes),
    .AUX_SETPOINT_PRESSURE_IN          (aux_p),
    .MAIN_SETPOINT_PRESSURE_IN         (main_p),
    .MANUAL_RESET_IN                   (man_rst),
    .ACTIVE_SETPOINT_OUT               (sp),
    .AUX_SETPOINT_SEL_OUT              (sel),
    .AUX_SETPOINT_INDICATOR_OUT        (aux_ind),
    .WATER_LACK_INDICATOR_OUT          (water),
    .MOTOR_DISABLED_INDICATOR_OUT      (motor),
    .LOW_INTAKE_PRESSURE_INDICATOR_OUT (lowp),
    .FAULT_RESET_OUT                   (fault),
    .SYSTEM_BLOCK_OUT                  (block)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (fault === 1'b1) begin
      fr_count <= fr_count + 1;
    end
  end

  task automatic summarize();
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [PRESS_W-1:0] seen,
                       input logic [PRESS_W-1:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask : check

  function automatic logic out_bit(input int s);
    case (s)
      0: return water;
      2: return lowp;
      3: return aux_ind;
      default: return logic'(sp === exp_sp);
    endcase
  endfunction : out_bit

  // cycles until an output reaches a level; running out ends the run
  task automatic wait_out(input int s, input logic val, input int lim,
                          output int cnt);
    cnt = 0;
    while (out_bit(s) !== val) begin
      if (cnt == lim) begin
        bad_count++;
        $display("wrong value at %0t: wait ran out", $time);
        summarize();
      end
      @(negedge clk);
      cnt++;
    end
  endtask : wait_out

  task automatic do_reset();
    @(negedge clk);
    rst_b <= 1'b0;
    codes <= '0;
    cmd <= '0;
    repeat (6) @(negedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
  endtask : do_reset

  initial begin
    rst_b = 1'b0;
    bounce = 1'b0;
    man_rst = 1'b0;
    cmd = '0;
    codes = '0;
    aux_p = {16'h0400, 16'h0200, 16'h0300, 16'h0100};
    main_p = 16'h0500;
    exp_sp = '0;
    bad_count = 0;
    samples_checked = 0;
    fr_count = 0;
    foreach (rows[r]) begin
      k = r % NUM_INPUTS;
      do_reset();
      codes[k] <= rows[r].code;
      cmd[k] <= rows[r].pin;
      fr_count = 0;
      repeat (30) @(negedge clk);
      check(water, rows[r].exp[4], "water lack");
      check(motor, rows[r].exp[3], "motor disabled");
      check(lowp, rows[r].exp[2], "low intake");
      check(aux_ind, rows[r].exp[1], "aux indicator");
      check(16'(fr_count), 16'(rows[r].exp[0]), "fault resets");
      check(block, |rows[r].exp[4:2], "system block");
      check(sp, rows[r].exp[1] ? aux_p[k] : main_p, "setpoint");
      check(16'(sel), rows[r].exp[1] ? 16'(1 << k) : '0, "sel");
    end
    $display("code table done");
    // outputs drop while reset is held, even with every float asserted
    codes <= {NUM_INPUTS{CODE_FLOAT_NO}};
    cmd <= '1;
    repeat (30) @(negedge clk);
    rst_b <= 1'b0;
    repeat (3) @(negedge clk);
    check(16'({water, block, aux_ind, lowp, motor}), '0, "in reset");
    check(sp, '0, "setpoint in reset");
    $display("reset test done");
    // a float blip shorter than a second is ignored
    do_reset();
    codes[0] <= CODE_FLOAT_NO;
    cmd[0] <= 1'b1;
    repeat (4) @(negedge clk);
    cmd[0] <= 1'b0;
    repeat (40) @(negedge clk);
    check(water, 1'b0, "short float");
    // chattering float on input 0, closed-contact float on input 1
    bounce <= 1'b1;
    cmd[0] <= 1'b1;
    cmd[1] <= 1'b1;
    codes[1] <= CODE_FLOAT_NC;
    wait_out(0, 1'b1, 40, n);
    check(16'(n >= 8), 16'h0001, "float entry time");
    check(block, 1'b1, "float blocks");
    cmd[1] <= 1'b0;
    cmd[0] <= 1'b0;
    repeat (280) @(negedge clk);
    check(water, 1'b1, "other float held");
    cmd[1] <= 1'b1;
    wait_out(0, 1'b0, 300, n);
    check(16'(n >= 240), 16'h0001, "float release time");
    bounce <= 1'b0;
    $display("float test done");
    // two aux setpoints: lowest wins, release waits a second
    do_reset();
    codes[1] <= CODE_AUX_NO;
    codes[2] <= CODE_AUX_NC;
    cmd[1] <= 1'b1;
    wait_out(3, 1'b1, 40, n);
    check(16'(n >= 8), 16'h0001, "aux entry time");
    repeat (20) @(negedge clk);
    check(sp, aux_p[2], "lowest aux");
    check(16'(sel), 16'h0004, "lowest sel");
    cmd[2] <= 1'b1;
    exp_sp = aux_p[1];
    wait_out(5, 1'b1, 40, n);
    check(16'(n >= 8), 16'h0001, "aux release time");
    $display("aux test done");
    // manual-only low pressure block, then automatic clear
    do_reset();
    codes[3] <= CODE_LOWP_MAN_NO;
    cmd[3] <= 1'b1;
    wait_out(2, 1'b1, 40, n);
    // a key reset while the switch still reports low pressure is ignored
    man_rst <= 1'b1;
    @(negedge clk);
    man_rst <= 1'b0;
    cmd[3] <= 1'b0;
    repeat (100) @(negedge clk);
    check(lowp, 1'b1, "manual block held");
    fr_count = 0;
    man_rst <= 1'b1;
    @(negedge clk);
    man_rst <= 1'b0;
    repeat (5) @(negedge clk);
    check(lowp, 1'b0, "manual clear");
    check(16'(fr_count), 16'h0001, "manual reset pulse");
    codes[3] <= CODE_LOWP_AUTO_NO;
    cmd[3] <= 1'b1;
    wait_out(2, 1'b1, 40, n);
    cmd[3] <= 1'b0;
    wait_out(2, 1'b0, 60, n);
    check(16'(n >= 16), 16'h0001, "auto clear time");
    $display("low pressure test done");
    summarize();
  end
endmodule : test_aux_input_function_mapper
`default_nettype wire
